// *** verilog/spt_pkg.sv ***
// Package with the shared constants and types of the lane timing block
package spt_pkg;

  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Least time rounds up to whole cycles, never below one
  function automatic int unsigned spt_min_cyc(input int unsigned t_ps);
    int unsigned c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : spt_min_cyc

  // Longest time rounds down to whole cycles, never below one
  function automatic int unsigned spt_max_cyc(input int unsigned t_ps);
    int unsigned c;
    c = t_ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : spt_max_cyc

  // Documented times in picoseconds
  localparam int unsigned TX_LAT_MAX_PS = 33200;
  localparam int unsigned RX_LAT_MAX_PS = 93200;
  localparam int unsigned LB_LAT_MAX_PS = 29200;
  localparam int unsigned LOCK_NOM_PS = 2000000;
  localparam int unsigned PWR_LAT_MAX_PS = 32000;
  localparam int unsigned RST_LAT_MAX_PS = 11000;
  localparam int unsigned RX_CLK_PERIOD_PS = 8000;

  // Derived cycle counts
  localparam int unsigned TX_LAT_CYC = spt_max_cyc(TX_LAT_MAX_PS);
  localparam int unsigned RX_LAT_CYC = spt_max_cyc(RX_LAT_MAX_PS);
  localparam int unsigned LB_LAT_CYC = spt_max_cyc(LB_LAT_MAX_PS);
  localparam int unsigned LOCK_CYC = spt_min_cyc(LOCK_NOM_PS);
  localparam int unsigned PWR_LAT_CYC = spt_max_cyc(PWR_LAT_MAX_PS);
  localparam int unsigned RST_LAT_CYC = spt_max_cyc(RST_LAT_MAX_PS);
  localparam int unsigned RX_CLK_CYC = spt_min_cyc(RX_CLK_PERIOD_PS);

  // Cycles spent in input synchroniser, edge detect and output flop
  localparam int unsigned SYNC_LAT_CYC = 4;
  // Cycles spent in the receive buffer and output stage
  localparam int unsigned RX_TAIL_CYC = 2;

  // Pipeline depths and wait counts
  localparam int unsigned TX_PIPE_DEPTH = TX_LAT_CYC - SYNC_LAT_CYC;
  localparam int unsigned RX_PIPE_DEPTH =
    RX_LAT_CYC - SYNC_LAT_CYC - RX_TAIL_CYC;
  localparam int unsigned LB_WAIT_CYC = LB_LAT_CYC - SYNC_LAT_CYC;
  localparam int unsigned PWR_WAIT_CYC =
    PWR_LAT_CYC - SYNC_LAT_CYC - RX_CLK_CYC;

  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SYM_W = 10;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned FTS_W = 8;
  localparam int unsigned BUF_DEPTH = 2;

  // Fast-training counts
  localparam logic [FTS_W-1:0] FTS_COMMON = 8'h17;
  localparam logic [FTS_W-1:0] FTS_SEPARATE = 8'hFF;

  // Reset values
  localparam logic DONE_RST = 1'h1;

  // Power-state select encoding
  typedef enum logic [1:0] {
    PWR_FULL = 2'h0,
    PWR_QUICK = 2'h1,
    PWR_DEEP = 2'h2,
    PWR_OFF = 2'h3
  } spt_pwr_type;

endpackage : spt_pkg

// *** verilog/spt_skid_buf.sv ***
// Two-entry valid/ready buffer with honest full and empty
`timescale 1ns/10ps
module spt_skid_buf
  import spt_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int unsigned IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic [IDX_W:0] count;
  } spt_buf_type;

  spt_buf_type st_ff;
  spt_buf_type nxt_st;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign in_ready_o = (st_ff.count != (IDX_W+1)'(DEPTH));
  assign out_valid_o = (st_ff.count != '0);
  assign out_data_o = st_ff.mem[st_ff.rd_idx];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next state: write, read and occupancy
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_idx] = in_data_i;
      nxt_st.wr_idx = (st_ff.wr_idx == IDX_W'(DEPTH-1)) ? '0 :
                      st_ff.wr_idx + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_idx = (st_ff.rd_idx == IDX_W'(DEPTH-1)) ? '0 :
                      st_ff.rd_idx + 1'b1;
    end
    // Simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : spt_skid_buf

// *** verilog/spt_phy_timing.sv ***
// Lane transceiver timing core: parallel side, serial side, power, lock
`timescale 1ns/10ps
module spt_phy_timing
  import spt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tx_clk_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  input wire logic detect_or_loopback_request_i,
  input wire logic [1:0] power_state_select_i,
  input wire logic common_clock_i,
  input wire logic [SYM_W-1:0] rx_symbol_i,
  input wire logic rx_symbol_valid_i,
  input wire logic rx_ready_i,
  output logic [SYM_W-1:0] tx_symbol_o,
  output logic tx_symbol_valid_o,
  output logic rx_clk_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_lane_ready_o,
  output logic rx_locked_o,
  output logic loopback_active_o,
  output logic [FTS_W-1:0] fast_training_count_o,
  output logic phy_done_indication_o
);

  // State of the core in one record; the receive buffer keeps its own
  typedef struct packed {
    // First synchroniser stage, read only by the second
    logic tx_clk_meta;
    logic [DATA_W-1:0] tx_data_meta;
    logic lb_meta;
    logic [1:0] pwr_meta;
    logic cc_meta;
    logic [SYM_W-1:0] rx_sym_meta;
    logic rx_val_meta;
    logic rx_rdy_meta;
    // Second synchroniser stage
    logic tx_clk_sync;
    logic [DATA_W-1:0] tx_data_sync;
    logic lb_sync;
    logic [1:0] pwr_sync;
    logic cc_sync;
    logic [SYM_W-1:0] rx_sym_sync;
    logic rx_val_sync;
    logic rx_rdy_sync;
    // Edge history
    logic tx_clk_prev;
    logic [1:0] pwr_prev;
    // Transmit delay line, valid in the top bit
    logic [TX_PIPE_DEPTH-1:0][DATA_W:0] tx_pipe;
    // Receive delay line, valid in the top bit
    logic [RX_PIPE_DEPTH-1:0][DATA_W:0] rx_pipe;
    // Loopback entry counter and state
    logic [CNT_W-1:0] lb_cnt;
    logic lb_active;
    // Lock counter and state
    logic [CNT_W-1:0] lock_cnt;
    logic locked;
    // Power return wait and done pulse
    logic pwr_wait;
    logic [CNT_W-1:0] pwr_cnt;
    logic [CNT_W-1:0] done_cnt;
    // Reset release counter
    logic [CNT_W-1:0] rst_cnt;
    // Registered outputs
    logic [SYM_W-1:0] tx_sym;
    logic tx_sym_valid;
    logic rx_clk;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic lane_ready;
    logic [FTS_W-1:0] fts;
    logic done;
  } spt_core_type;

  spt_core_type st_ff;
  spt_core_type nxt_st;

  // Receive buffer handshakes
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [DATA_W-1:0] buf_out_data;

  // Symbol framing stand-in for the line code: marker bits over the byte
  function automatic logic [SYM_W-1:0] spt_encode(input logic [DATA_W-1:0] d);
    return {2'h2, d};
  endfunction : spt_encode

  // Counter step that saturates at its limit
  function automatic logic [CNT_W-1:0] spt_step(input logic [CNT_W-1:0] c,
                                                 input int unsigned lim);
    return (c >= CNT_W'(lim)) ? c : c + 1'b1;
  endfunction : spt_step

  // Buffer feed is the tail of the receive delay line
  assign buf_in_valid = st_ff.rx_pipe[RX_PIPE_DEPTH-1][DATA_W];
  // Drain only when the controller is not stalling
  assign buf_out_ready = st_ff.rx_rdy_sync;

  // Two-entry buffer; during a controller stall a byte reaching it while full is dropped
  // Two entries cover the synchroniser delay of the ready input; a
  // longer stall fills the buffer and back-pressure goes to the lane.
  spt_skid_buf #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(st_ff.rx_pipe[RX_PIPE_DEPTH-1][DATA_W-1:0]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // Next-state logic for the core; the receive buffer computes its own
  // Every input is read only after its second flop; the first stage
  // may be metastable and must feed nothing but the second stage.
  // The cost is about four cycles of latency on every path, which the
  // pipeline depths in the package already subtract from the limits.
  always_comb begin
    logic tx_edge;
    logic at_full;
    logic wake;
    logic paths_ready;
    tx_edge = 1'b0;
    at_full = 1'b0;
    wake = 1'b0;
    paths_ready = 1'b0;
    nxt_st = st_ff;

    // Two-flop synchronisers on every outside input
    nxt_st.tx_clk_meta = tx_clk_i;
    nxt_st.tx_data_meta = tx_data_i;
    nxt_st.lb_meta = detect_or_loopback_request_i;
    nxt_st.pwr_meta = power_state_select_i;
    nxt_st.cc_meta = common_clock_i;
    nxt_st.rx_sym_meta = rx_symbol_i;
    nxt_st.rx_val_meta = rx_symbol_valid_i;
    nxt_st.rx_rdy_meta = rx_ready_i;
    nxt_st.tx_clk_sync = st_ff.tx_clk_meta;
    nxt_st.tx_data_sync = st_ff.tx_data_meta;
    nxt_st.lb_sync = st_ff.lb_meta;
    nxt_st.pwr_sync = st_ff.pwr_meta;
    nxt_st.cc_sync = st_ff.cc_meta;
    nxt_st.rx_sym_sync = st_ff.rx_sym_meta;
    nxt_st.rx_val_sync = st_ff.rx_val_meta;
    nxt_st.rx_rdy_sync = st_ff.rx_rdy_meta;
    nxt_st.tx_clk_prev = st_ff.tx_clk_sync;
    nxt_st.pwr_prev = st_ff.pwr_sync;

    // Both transmit clock edges carry a byte
    tx_edge = st_ff.tx_clk_sync ^ st_ff.tx_clk_prev;
    at_full = (st_ff.pwr_sync == PWR_FULL);

    // Transmit delay line; bytes only accepted at full power
    // A byte on an edge outside full power is dropped, not held, so a
    // controller that sends while idle loses that byte.
    nxt_st.tx_pipe[0] = {tx_edge && at_full, st_ff.tx_data_sync};
    for (int i = 1; i < TX_PIPE_DEPTH; i++) begin
      nxt_st.tx_pipe[i] = st_ff.tx_pipe[i-1];
    end

    // Loopback entry counted from the synchronised request
    // Dropping the request ends loopback at once; no drain is needed
    // because the looped path holds no state of its own.
    if (st_ff.lb_sync) begin
      nxt_st.lb_cnt = spt_step(st_ff.lb_cnt, LB_WAIT_CYC);
      // Entry time fixed so the worst case still fits
      nxt_st.lb_active = (st_ff.lb_cnt >= CNT_W'(LB_WAIT_CYC - 1));
    end else begin
      nxt_st.lb_cnt = '0;
      nxt_st.lb_active = 1'b0;
    end

    // Serial transmit output, loopback takes precedence
    if (st_ff.lb_active) begin
      nxt_st.tx_sym = st_ff.rx_sym_sync;
      nxt_st.tx_sym_valid = st_ff.rx_val_sync;
    end else begin
      nxt_st.tx_sym = spt_encode(st_ff.tx_pipe[TX_PIPE_DEPTH-1][DATA_W-1:0]);
      nxt_st.tx_sym_valid = st_ff.tx_pipe[TX_PIPE_DEPTH-1][DATA_W];
    end

    // Lock after a steady run of valid training symbols
    // Counts the nominal acquisition time, which leaves half the allowed
    // lock window as margin for a slow training sequence.
    if (st_ff.rx_val_sync && at_full) begin
      nxt_st.lock_cnt = spt_step(st_ff.lock_cnt, LOCK_CYC);
      nxt_st.locked = (st_ff.lock_cnt >= CNT_W'(LOCK_CYC - 1));
    end else begin
      // Loss of signal restarts acquisition
      nxt_st.lock_cnt = '0;
      nxt_st.locked = 1'b0;
    end

    // Receive delay line fed with decoded bytes once locked
    // Symbols before lock carry no trusted byte and are discarded here.
    nxt_st.rx_pipe[0] = {st_ff.rx_val_sync && st_ff.locked,
                         st_ff.rx_sym_sync[DATA_W-1:0]};
    for (int i = 1; i < RX_PIPE_DEPTH; i++) begin
      nxt_st.rx_pipe[i] = st_ff.rx_pipe[i-1];
    end

    // Receive clock toggles every cycle: 8 ns period
    nxt_st.rx_clk = ~st_ff.rx_clk;
    // Output updates on every receive clock edge
    nxt_st.rx_valid = buf_out_valid && buf_out_ready;
    if (buf_out_valid && buf_out_ready) begin
      nxt_st.rx_data = buf_out_data;
    end
    // Back-pressure toward the serial source
    nxt_st.lane_ready = buf_in_ready;

    // Fast-training count advertised from the clocking strap
    nxt_st.fts = st_ff.cc_sync ? FTS_COMMON : FTS_SEPARATE;

    // Return from either idle state to full power
    // The off state is not a wake source: leaving it is a fresh start
    // and raises no completion pulse.
    wake = at_full && ((st_ff.pwr_prev == PWR_QUICK) ||
                       (st_ff.pwr_prev == PWR_DEEP));
    if (wake) begin
      nxt_st.pwr_wait = 1'b1;
      nxt_st.pwr_cnt = '0;
    end else if (st_ff.pwr_wait) begin
      nxt_st.pwr_cnt = spt_step(st_ff.pwr_cnt, PWR_WAIT_CYC);
    end
    // Transmit path idle-clean at its first stage and allowed to run
    paths_ready = at_full && !st_ff.tx_pipe[0][DATA_W];

    // Reset release and power-return completion
    // One chain of priorities drives the completion flag, so reset
    // release, pulse hold and wake completion never fight over it.
    if (st_ff.rst_cnt < CNT_W'(RST_LAT_CYC - 1)) begin
      nxt_st.rst_cnt = st_ff.rst_cnt + 1'b1;
      nxt_st.done = DONE_RST;
    end else if (st_ff.rst_cnt == CNT_W'(RST_LAT_CYC - 1)) begin
      // Ready after reset: completion falls here
      nxt_st.rst_cnt = st_ff.rst_cnt + 1'b1;
      nxt_st.done = 1'b0;
    end else if (st_ff.done_cnt != '0) begin
      // Hold the pulse for one receive clock period
      nxt_st.done_cnt = st_ff.done_cnt - 1'b1;
      // Flag stays high while the hold count runs down
      nxt_st.done = 1'b1;
    end else if (st_ff.pwr_wait && paths_ready &&
                 st_ff.pwr_cnt >= CNT_W'(PWR_WAIT_CYC - 1)) begin
      // A wake in the same cycle keeps the wait armed
      nxt_st.pwr_wait = wake;
      nxt_st.done = 1'b1;
      nxt_st.done_cnt = CNT_W'(RX_CLK_CYC - 1);
    end else begin
      nxt_st.done = 1'b0;
    end
  end

  // State register; reset leaves completion asserted
  // Reset values are constants only; the power history starts at full
  // power so that reset release is not mistaken for a wake.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.pwr_sync <= PWR_FULL;
      st_ff.pwr_prev <= PWR_FULL;
      st_ff.fts <= FTS_SEPARATE;
      st_ff.done <= DONE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output straight from a register
  // No output passes through logic after its flop, so the controller
  // sees clean edges with a full cycle of settling.
  assign tx_symbol_o = st_ff.tx_sym;
  assign tx_symbol_valid_o = st_ff.tx_sym_valid;
  assign rx_clk_o = st_ff.rx_clk;
  assign rx_data_o = st_ff.rx_data;
  assign rx_valid_o = st_ff.rx_valid;
  assign rx_lane_ready_o = st_ff.lane_ready;
  assign rx_locked_o = st_ff.locked;
  assign loopback_active_o = st_ff.lb_active;
  assign fast_training_count_o = st_ff.fts;
  assign phy_done_indication_o = st_ff.done;

endmodule : spt_phy_timing

// *** test/spt_phy_timing_properties.sv ***
// Checker of the lane timing block, bound to its top module
`timescale 1ns/10ps
module spt_phy_timing_props
  import spt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tx_clk_i,
  input wire logic detect_or_loopback_request_i,
  input wire logic [1:0] power_state_select_i,
  input wire logic common_clock_i,
  input wire logic rx_symbol_valid_i,
  input wire logic tx_symbol_valid_o,
  input wire logic rx_clk_o,
  input wire logic rx_locked_o,
  input wire logic loopback_active_o,
  input wire logic [FTS_W-1:0] fast_training_count_o,
  input wire logic phy_done_indication_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Run of training symbols at full power, saturating
  logic [10:0] lock_cnt_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !rx_symbol_valid_i || power_state_select_i != PWR_FULL) begin
      lock_cnt_ff <= 11'h000;
    end else if (lock_cnt_ff != 11'h7FF) begin
      lock_cnt_ff <= lock_cnt_ff + 11'h001;
    end
  end
  a_tx_latency: assert property (
    $changed(tx_clk_i) && power_state_select_i == PWR_FULL &&
    !detect_or_loopback_request_i |-> ##[1:8] tx_symbol_valid_o)
    else $error("transmit symbol late");
  a_loopback_entry: assert property (
    $rose(detect_or_loopback_request_i) |-> ##[1:6] loopback_active_o)
    else $error("loopback late");
  a_fts_common: assert property (
    common_clock_i [*5] |-> fast_training_count_o == FTS_COMMON)
    else $error("training count wrong, common clock");
  a_fts_separate: assert property (
    !common_clock_i [*5] |-> fast_training_count_o == FTS_SEPARATE)
    else $error("training count wrong, separate clocks");
  a_lock_time: assert property (
    lock_cnt_ff == 11'h3E8 |-> rx_locked_o)
    else $error("lock not reached in time");
  a_wake_done: assert property (
    $past(power_state_select_i) inside {PWR_QUICK, PWR_DEEP} &&
    power_state_select_i == PWR_FULL |-> ##[1:8] phy_done_indication_o)
    else $error("wake completion late");
  a_done_width: assert property (
    $rose(phy_done_indication_o) |=> phy_done_indication_o ##1
    !phy_done_indication_o)
    else $error("completion pulse width wrong");
  a_reset_ready: assert property (
    $fell(rst_i) |-> ##[1:2] !phy_done_indication_o)
    else $error("completion not cleared after reset");
  a_rx_clk_run: assert property (
    !rst_i ##1 !rst_i |-> $changed(rx_clk_o))
    else $error("receive clock stalled");
  // Main scenarios reached
  c_tx: cover property (tx_symbol_valid_o);
  c_lock: cover property ($rose(rx_locked_o));
  c_wake: cover property ($rose(phy_done_indication_o));
endmodule : spt_phy_timing_props

bind spt_phy_timing spt_phy_timing_props chk_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_clk_i(tx_clk_i),
  .detect_or_loopback_request_i(detect_or_loopback_request_i),
  .power_state_select_i(power_state_select_i),
  .common_clock_i(common_clock_i), .rx_symbol_valid_i(rx_symbol_valid_i),
  .tx_symbol_valid_o(tx_symbol_valid_o), .rx_clk_o(rx_clk_o),
  .rx_locked_o(rx_locked_o), .loopback_active_o(loopback_active_o),
  .fast_training_count_o(fast_training_count_o),
  .phy_done_indication_o(phy_done_indication_o)
);

// *** test/spt_mac_model.sv ***
// Controller-side model: idle-stopped transmit clock, byte on each edge
`timescale 1ns/10ps
module spt_mac_model
  import spt_pkg::*;
(
  output logic tx_clk_o,
  output logic [DATA_W-1:0] tx_data_o
);
  // Clock stands still between frames
  initial begin
    tx_clk_o = 1'h0;
    tx_data_o = 8'h00;
  end
  // One half period of a 48 ns clock per byte
  task automatic send(input logic [DATA_W-1:0] b);
    tx_data_o = b;
    #12;
    tx_clk_o = ~tx_clk_o;
    #12; // Byte held a quarter period past its edge
  endtask : send
endmodule : spt_mac_model

// *** test/tb_top.sv ***
// Self-checking bench of the lane timing block
`timescale 1ns/10ps
module tb_top
  import spt_pkg::*;
;
  localparam logic [SYM_W-1:0] TRAIN_SYM = 10'h2BC; // Training symbol
  logic clk_sys_i, rst_i, tx_clk_i, detect_or_loopback_request_i;
  logic common_clock_i, rx_symbol_valid_i, rx_ready_i, tx_symbol_valid_o;
  logic rx_clk_o, rx_valid_o, rx_lane_ready_o, rx_locked_o;
  logic loopback_active_o, phy_done_indication_o;
  logic [1:0] power_state_select_i;
  logic [DATA_W-1:0] tx_data_i, rx_data_o, b;
  logic [SYM_W-1:0] rx_symbol_i, tx_symbol_o;
  logic [FTS_W-1:0] fast_training_count_o;
  logic [DATA_W-1:0] txq[$], rxq[$]; // Expected bytes
  int n_errors = 0, cmp_count = 0, seed = 15, w, rx_pulses = 0;
  bit lb_on = 0; // Loopback scenario running
  spt_mac_model mac_u (.tx_clk_o(tx_clk_i), .tx_data_o(tx_data_i));
  spt_phy_timing dut_u (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tx_clk_i(tx_clk_i),
    .tx_data_i(tx_data_i),
    .detect_or_loopback_request_i(detect_or_loopback_request_i),
    .power_state_select_i(power_state_select_i),
    .common_clock_i(common_clock_i),
    .rx_symbol_i(rx_symbol_i),
    .rx_symbol_valid_i(rx_symbol_valid_i),
    .rx_ready_i(rx_ready_i),
    .tx_symbol_o(tx_symbol_o),
    .tx_symbol_valid_o(tx_symbol_valid_o),
    .rx_clk_o(rx_clk_o),
    .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o),
    .rx_lane_ready_o(rx_lane_ready_o),
    .rx_locked_o(rx_locked_o),
    .loopback_active_o(loopback_active_o),
    .fast_training_count_o(fast_training_count_o),
    .phy_done_indication_o(phy_done_indication_o)
  );
  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Output monitors, sampled off the launch edge
  always @(negedge clk_sys_i) begin
    if (tx_symbol_valid_o === 1'h1 && !lb_on) begin
      if (txq.size() == 0) begin
        check("dropped byte sent", 1, 0);
      end else begin
        check("tx symbol", tx_symbol_o, {2'h2, txq.pop_front()});
      end
    end
    if (rx_valid_o === 1'h1) begin
      rx_pulses++;
      if (rx_data_o !== TRAIN_SYM[7:0] && rxq.size() > 0) begin
        check("rx byte", rx_data_o, rxq.pop_front());
      end
    end
  end
  // Hang guard, several times the expected run
  initial begin
    #60000;
    n_errors++;
    $display("timeout");
    stop_test();
  end
  initial begin
    {rst_i, rx_ready_i, common_clock_i} = 3'h7;
    {detect_or_loopback_request_i, rx_symbol_valid_i} = 2'h0;
    power_state_select_i = PWR_FULL;
    rx_symbol_i = TRAIN_SYM;
    tick(2);
    check("done in reset", phy_done_indication_o, DONE_RST);
    rst_i = 1'h0;
    tick(2);
    check("done after reset", phy_done_indication_o, 0);
    for (int c = 1; c >= 0; c--) begin
      common_clock_i = c[0];
      tick(6);
      check("fts", fast_training_count_o, c ? FTS_COMMON : FTS_SEPARATE);
    end
    $display("test reset and training count done");
    for (int i = 0; i < 18; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      txq.push_back(b);
      mac_u.send(b);
    end
    tick(6);
    check("tx all sent", txq.size(), 0);
    $display("test transmit done");
    for (int i = 1; i < 4; i++) begin
      power_state_select_i = 2'(i);
      tick(6);
      mac_u.send(8'($random(seed))); // Refused while not at full power
      tick(12);
      power_state_select_i = PWR_FULL;
      w = 0;
      while (phy_done_indication_o !== 1'h1 && w < 20) begin
        tick(1);
        w++;
      end
      if (i < 3) begin
        check("wake time ok", w <= 8, 1);
        tick(1);
        check("done second cycle", phy_done_indication_o, 1);
        tick(1);
        check("done cleared", phy_done_indication_o, 0);
      end else begin
        check("no wake from off", w, 20);
      end
      tick(10);
    end
    $display("test power states done");
    rx_symbol_valid_i = 1'h1;
    w = 0;
    while (rx_locked_o !== 1'h1 && w < 1100) begin
      tick(1);
      w++;
    end
    check("lock time ok", w <= 1000, 1);
    repeat (24) begin
      b = 8'($random(seed)) | 8'h01;
      rxq.push_back(b);
      rx_symbol_i = {2'h1, b};
      tick(1);
    end
    rx_symbol_i = TRAIN_SYM;
    tick(23);
    check("rx all received", rxq.size(), 0);
    rx_ready_i = 1'h0;
    tick(8);
    w = rx_pulses;
    tick(30);
    check("stall holds output", rx_pulses, w);
    check("buffer full", rx_lane_ready_o, 0);
    rx_ready_i = 1'h1;
    tick(8);
    check("drain resumed", rx_pulses > w, 1);
    $display("test receive done");
    lb_on = 1'h1;
    detect_or_loopback_request_i = 1'h1;
    w = 0;
    while (loopback_active_o !== 1'h1 && w < 20) begin
      tick(1);
      w++;
    end
    check("loopback time ok", w <= 6, 1);
    tick(4);
    check("looped symbol", tx_symbol_o, TRAIN_SYM);
    detect_or_loopback_request_i = 1'h0;
    tick(20);
    lb_on = 1'h0;
    tick(500);
    check("lock kept", rx_locked_o, 1);
    $display("test loopback done");
    stop_test();
  end
endmodule : tb_top
